// ---- hw/card_page_read_path.sv ----
// Card page read path with Wishbone register slave
`timescale 1ns/1ns
module card_page_read_path (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             irq_o,
  output logic             dma_req_o,
  input  wire logic [7:0]  card_io_i,
  output logic [7:0]       card_io_o,
  output logic             card_io_oe_o,
  output logic             card_cle_o,
  output logic             card_ale_o,
  output logic             card_we_n_o,
  output logic             card_re_n_o,
  output logic             card_ce_n_o,
  input  wire logic        card_rb_n_i
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [7:0] io_meta;
  logic [7:0] io_sync;
  logic       rb_meta;
  logic       rb_sync;
  always_ff @(posedge clk_i) begin
    io_meta <= card_io_i;
    io_sync <= io_meta;
    rb_meta <= card_rb_n_i;
    rb_sync <= rb_meta;
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic acc;
  logic wr;
  logic rd;
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr  = acc && we_i;
  assign rd  = acc && !we_i;

  logic [31:0] cmd_reg;
  logic [31:0] addr_reg;
  logic [31:0] card_read_data;
  logic        dma_mode;
  logic [2:0]  status;
  logic [2:0]  mask;
  card_read_pkg::state_e state;
  logic [9:0]  byte_cnt;
  logic [7:0]  word_cnt;
  logic [3:0]  timer;
  logic        phase;
  logic [1:0]  addr_idx;
  logic [23:0] pack;
  logic        word_ev;
  logic        done_ev;
  logic        bad_ev;
  logic        start;
  logic        pop;
  logic        busy_seen;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg  <= card_read_pkg::RESET_WORD;
      addr_reg <= card_read_pkg::RESET_WORD;
      dma_mode <= 1'b0;
      mask     <= 3'h0;
    end else if (wr) begin
      if (hit(adr_i, card_read_pkg::OFS_CMD)) begin
        cmd_reg <= merge(cmd_reg, dat_i, sel_i);
      end
      if (hit(adr_i, card_read_pkg::OFS_ADDR)) begin
        addr_reg <= merge(addr_reg, dat_i, sel_i);
      end
      if (hit(adr_i, card_read_pkg::OFS_CTRL) && sel_i[0]) begin
        dma_mode <= dat_i[card_read_pkg::CTRL_DMA];
      end
      if (hit(adr_i, card_read_pkg::OFS_MASK) && sel_i[0]) begin
        mask <= dat_i[2:0];
      end
    end
  end

  // Address write launches a page read; bad code only flags
  logic [7:0] cmd_code;
  assign cmd_code = cmd_reg[card_read_pkg::CMD_CODE_LSB +: 8];
  assign start = wr && hit(adr_i, card_read_pkg::OFS_ADDR) && state == card_read_pkg::S_IDLE
                 && cmd_code == card_read_pkg::CMD_READ; // RULE6
  assign bad_ev = wr && hit(adr_i, card_read_pkg::OFS_ADDR)
                  && cmd_code != card_read_pkg::CMD_READ; // RULE6
  assign pop = rd && hit(adr_i, card_read_pkg::OFS_DATA) && state == card_read_pkg::S_HOLD;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= card_read_pkg::RESET_WORD;
    end else if (rd) begin
      case (adr_i)
        card_read_pkg::OFS_CMD:  dat_o <= cmd_reg;
        card_read_pkg::OFS_ADDR: dat_o <= addr_reg;
        card_read_pkg::OFS_DATA: dat_o <= card_read_data; // RULE1
        card_read_pkg::OFS_CTRL: dat_o <= {31'h0, dma_mode};
        card_read_pkg::OFS_STAT: dat_o <= {23'h0, state != card_read_pkg::S_IDLE, 5'h0, status};
        card_read_pkg::OFS_MASK: dat_o <= {29'h0, mask};
        default:                 dat_o <= card_read_pkg::RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // Status, interrupt and DMA request
  // ----------------------------------------
  logic [2:0] set_bits;
  logic [2:0] clr_bits;
  assign set_bits = {bad_ev, done_ev, word_ev && !dma_mode};
  assign clr_bits = (wr && hit(adr_i, card_read_pkg::OFS_STAT) && sel_i[0]) ? dat_i[2:0] : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~clr_bits) | set_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o     <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      irq_o     <= |(((status & ~clr_bits) | set_bits) & mask); // RULE9
      dma_req_o <= dma_mode && (state == card_read_pkg::S_HOLD || word_ev) && !pop; // RULE9
    end
  end

  // ----------------------------------------
  // Card access sequencer
  // ----------------------------------------
  logic strobe_end;
  assign strobe_end = (timer == card_read_pkg::STROBE_CYC - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer <= 4'h0;
      phase <= 1'b0;
    end else if (state == card_read_pkg::S_IDLE || state == card_read_pkg::S_BUSY
                 || state == card_read_pkg::S_HOLD) begin
      timer <= 4'h0;
      phase <= 1'b0;
    end else if (strobe_end) begin
      timer <= 4'h0;
      phase <= !phase;
    end else begin
      timer <= timer + 4'h1;
    end
  end

  logic cycle_end;
  assign cycle_end = strobe_end && phase;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= card_read_pkg::S_IDLE;
      addr_idx <= 2'h0;
      byte_cnt <= 10'h0;
      word_cnt <= 8'h0;
    end else begin
      case (state)
        card_read_pkg::S_IDLE: begin
          if (start) begin
            state    <= card_read_pkg::S_CMD; // RULE8
            addr_idx <= 2'h0;
            byte_cnt <= 10'h0;
            word_cnt <= 8'h0;
          end
        end
        card_read_pkg::S_CMD: begin
          if (cycle_end) begin
            state <= card_read_pkg::S_ADDR; // RULE8
          end
        end
        card_read_pkg::S_ADDR: begin
          if (cycle_end) begin
            addr_idx <= addr_idx + 2'h1;
            if (addr_idx == card_read_pkg::ADDR_BYTES) begin
              state <= card_read_pkg::S_BUSY;
            end
          end
        end
        card_read_pkg::S_BUSY: begin
          if (rb_sync && timer == 4'h0 && phase == 1'b0 && busy_seen) begin
            state <= card_read_pkg::S_READ;
          end
        end
        card_read_pkg::S_READ: begin
          if (cycle_end) begin
            byte_cnt <= byte_cnt + 10'h1; // RULE10
            if (byte_cnt[1:0] == 2'h3) begin
              state <= card_read_pkg::S_HOLD;
            end
          end
        end
        card_read_pkg::S_HOLD: begin
          if (pop) begin
            word_cnt <= word_cnt + 8'h1; // RULE4
            if (word_cnt == card_read_pkg::PAGE_WORDS - 8'h1) begin
              state <= card_read_pkg::S_IDLE; // RULE11
            end else begin
              state <= card_read_pkg::S_READ;
            end
          end
        end
        default: state <= card_read_pkg::S_IDLE;
      endcase
    end
  end

  // Wait for ready/busy to drop then rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_seen <= 1'b0;
    end else if (state != card_read_pkg::S_BUSY) begin
      busy_seen <= 1'b0;
    end else if (!rb_sync) begin
      busy_seen <= 1'b1;
    end
  end

  // ----------------------------------------
  // Byte packing
  // ----------------------------------------
  logic take;
  assign take = state == card_read_pkg::S_READ && strobe_end && !phase;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pack           <= 24'h0;
      card_read_data <= card_read_pkg::RESET_WORD;
      word_ev        <= 1'b0;
    end else begin
      // Word is offered only once the last strobe has closed
      word_ev <= (state == card_read_pkg::S_READ) && cycle_end && byte_cnt[1:0] == 2'h3; // RULE9
      if (take) begin
        case (byte_cnt[1:0])
          2'h0:    pack[7:0]   <= io_sync; // RULE2
          2'h1:    pack[15:8]  <= io_sync; // RULE2
          2'h2:    pack[23:16] <= io_sync; // RULE2
          default: begin
            card_read_data <= {io_sync, pack}; // RULE1 RULE2
          end
        endcase
      end
    end
  end

  assign done_ev = pop && word_cnt == card_read_pkg::PAGE_WORDS - 8'h1;

  // ----------------------------------------
  // Card pins
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_io_o    <= 8'h00;
      card_io_oe_o <= 1'b0;
      card_cle_o   <= 1'b0;
      card_ale_o   <= 1'b0;
      card_we_n_o  <= 1'b1;
      card_re_n_o  <= 1'b1;
      card_ce_n_o  <= 1'b1;
    end else begin
      card_ce_n_o  <= (state == card_read_pkg::S_IDLE);
      card_cle_o   <= (state == card_read_pkg::S_CMD);
      card_ale_o   <= (state == card_read_pkg::S_ADDR);
      card_io_oe_o <= (state == card_read_pkg::S_CMD || state == card_read_pkg::S_ADDR);
      card_we_n_o  <= !((state == card_read_pkg::S_CMD || state == card_read_pkg::S_ADDR)
                        && !phase);
      card_re_n_o  <= !(state == card_read_pkg::S_READ && !phase);
      case (addr_idx)
        2'h0:    card_io_o <= (state == card_read_pkg::S_CMD) ? cmd_code : 8'h00;
        2'h1:    card_io_o <= addr_reg[7:0];
        2'h2:    card_io_o <= addr_reg[15:8];
        default: card_io_o <= addr_reg[23:16];
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_data_on_word: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    take && byte_cnt[1:0] == 2'h3 |=> card_read_data[31:24] == $past(io_sync))
    else $error("data register missed fourth byte");
  a_first_byte_low: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    take && byte_cnt[1:0] == 2'h0 |=> pack[7:0] == $past(io_sync))
    else $error("first byte not in low lane");
  a_last_word_idle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    pop && word_cnt == card_read_pkg::PAGE_WORDS - 8'h1 |=> state == card_read_pkg::S_IDLE)
    else $error("page not ended after 132 reads");
  a_bad_code_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    bad_ev && state == card_read_pkg::S_IDLE |=> state == card_read_pkg::S_IDLE && status[2])
    else $error("bad command code started a read");
  a_cmd_before_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    start |=> state == card_read_pkg::S_CMD ##1 card_cle_o && !card_ale_o)
    else $error("command phase not first");
  a_word_raises_req: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    word_ev && !dma_mode |=> status[0])
    else $error("word did not set status");
  a_dma_req_word: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    word_ev && dma_mode && !pop |=> dma_req_o)
    else $error("word did not raise dma request");
  a_page_bytes: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    state == card_read_pkg::S_HOLD |-> byte_cnt == {word_cnt, 2'h0} + 10'h4)
    else $error("byte and word counts disagree");
  a_no_read_idle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    state == card_read_pkg::S_IDLE && !start |=> state == card_read_pkg::S_IDLE)
    else $error("left idle without start");
endmodule : card_page_read_path

// ---- hw/card_read_pkg.sv ----
// Constants for the card page read path
// Notes on behaviour
// RULE1: Read data register holds latest card bytes
// RULE2: First byte low, fourth byte high
// RULE3: Processor or DMA reads each word
// RULE4: 132 consecutive data reads drain page
// RULE5: Command word xxxx00yy, low byte ignored
// RULE6: Only read code 00h is accepted
// RULE7: Software then writes target page address
// RULE8: Device sends command then address to card
// RULE9: Each word raises interrupt or DMA request
// RULE10: Every read moves full 528-byte page
// RULE11: After last word return to idle
package card_read_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD  = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int CMD_CODE_LSB = 8;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam int CTRL_DMA = 0;
  localparam int ST_WORD = 0;
  localparam int ST_DONE = 1;
  localparam int ST_BAD  = 2;
  localparam int ST_BUSY = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------
  // Page geometry and timing
  // ----------------------------------------
  localparam logic [9:0] PAGE_BYTES = 10'h210;
  localparam logic [7:0] PAGE_WORDS = 8'h84;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam int CLK_MHZ = 100;
  localparam int STROBE_NS = 40;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD  = 3'b001,
    S_ADDR = 3'b010,
    S_BUSY = 3'b011,
    S_READ = 3'b100,
    S_HOLD = 3'b101
  } state_e;
endpackage : card_read_pkg

// ---- dv/card_model.sv ----
// Behavioural flash card answering page reads
`timescale 1ns/1ns
module card_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  busy_len_i,
  input  wire logic [7:0]  io_i,
  input  wire logic        oe_i,
  input  wire logic        cle_i,
  input  wire logic        ale_i,
  input  wire logic        we_n_i,
  input  wire logic        re_n_i,
  input  wire logic        ce_n_i,
  output logic [7:0]       io_o,
  output logic             rb_n_o,
  output logic [7:0]       cmd_o,
  output logic [23:0]      page_o,
  output int               cmd_cnt_o,
  output int               byte_cnt_o
);
  logic [7:0] drv  = 8'h00;
  logic [1:0] acnt = 2'h0;
  logic       go   = 1'b0;
  logic       go_q = 1'b0;
  int         bcnt = 0;
  initial begin
    rb_n_o = 1'b1;
    cmd_o = 8'h00;
    page_o = 24'h00_0000;
    cmd_cnt_o = 0;
    byte_cnt_o = 0;
  end
  // ----------------------------------------
  // Command and address latch
  // ----------------------------------------
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_i && cle_i) begin
      cmd_o <= io_i;
      cmd_cnt_o <= cmd_cnt_o + 1;
      acnt <= 2'h0;
    end else if (!ce_n_i && oe_i && ale_i) begin
      if (acnt != 2'h0) page_o <= {io_i, page_o[23:8]};
      if (acnt == 2'h3) go <= ~go;
      acnt <= acnt + 2'h1;
    end
  end
  // ----------------------------------------
  // Busy period and data out
  // ----------------------------------------
  always @(posedge clk_i) begin
    go_q <= go;
    if (rst_i) begin
      rb_n_o <= 1'b1;
      bcnt <= 0;
    end else if (go != go_q) begin
      rb_n_o <= 1'b0;
      bcnt <= int'(busy_len_i);
    end else if (bcnt > 1) bcnt <= bcnt - 1;
    else rb_n_o <= 1'b1;
  end
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      drv <= byte_cnt_o[7:0] ^ page_o[7:0];
      byte_cnt_o <= byte_cnt_o + 1;
    end
  end
  // Released bus shows the inverse of the last byte
  assign io_o = (!re_n_i && !ce_n_i) ? drv : ~drv;
endmodule : card_model

// ---- dv/card_page_read_path_bench.sv ----
// Self-checking bench for the card page read path
`timescale 1ns/1ns
module card_page_read_path_bench;
  logic clk = 1'b0;
  logic rst, cyc, stb, we, irq_o, dma_req_o, ack_o, oe, cle, ale, we_n, re_n, ce_n, rb_n;
  logic [7:0] adr, busy_len, io_out, io_in, cmd_byte;
  logic [31:0] wdat, dat_o;
  logic [23:0] page_seen;
  int cmd_cnt, byte_cnt, err_total = 0, checks = 0;
  always #5 clk = ~clk;
  card_page_read_path dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .dma_req_o(dma_req_o), .card_io_i(io_in), .card_io_o(io_out), .card_io_oe_o(oe),
    .card_cle_o(cle), .card_ale_o(ale), .card_we_n_o(we_n), .card_re_n_o(re_n),
    .card_ce_n_o(ce_n), .card_rb_n_i(rb_n));
  card_model card_u (.clk_i(clk), .rst_i(rst), .busy_len_i(busy_len), .io_i(io_out), .oe_i(oe),
    .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .ce_n_i(ce_n), .io_o(io_in),
    .rb_n_o(rb_n), .cmd_o(cmd_byte), .page_o(page_seen), .cmd_cnt_o(cmd_cnt),
    .byte_cnt_o(byte_cnt));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task give_verdict();
    $display("Checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack_o !== 1'b1) begin
      chk("bus ack", 1, ack_o);
      give_verdict();
    end
  endtask : wb
  task automatic wait_lvl(input logic dma, input logic lvl);
    logic s;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      s = dma ? dma_req_o : irq_o;
      if (s === lvl) return;
    end
    chk("request level", lvl, s);
    give_verdict();
  endtask : wait_lvl
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_regs();
    logic [31:0] q;
    chk("idle outputs", 32'h0000_0002, {irq_o, dma_req_o, ce_n, oe});
    wb(1'b1, card_read_pkg::OFS_DATA, 32'hFFFF_FFFF, q);
    wb(1'b0, card_read_pkg::OFS_DATA, 32'h0, q);
    chk("data read only", card_read_pkg::RESET_WORD, q);
    wb(1'b1, 8'h20, 32'h5555_5555, q);
    wb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", 32'h0000_0000, q);
    wb(1'b1, card_read_pkg::OFS_CMD, 32'h1234_00A5, q);
    wb(1'b0, card_read_pkg::OFS_CMD, 32'h0, q);
    chk("command word", 32'h1234_00A5, q);
    wb(1'b0, card_read_pkg::OFS_STAT, 32'h0, q);
    chk("status reset", 32'h0000_0000, q);
  endtask : reset_regs
  task automatic run_page(input logic dma, input logic [23:0] page, input logic [7:0] bl);
    logic [31:0] q, e;
    int c0, b0;
    c0 = cmd_cnt;
    b0 = byte_cnt;
    busy_len <= bl;
    wb(1'b1, card_read_pkg::OFS_CTRL, {31'h0, dma}, q);
    wb(1'b1, card_read_pkg::OFS_MASK, 32'h0000_0001, q);
    wb(1'b1, card_read_pkg::OFS_CMD, 32'hBEEF_00A5, q);
    wb(1'b1, card_read_pkg::OFS_ADDR, {8'h00, page}, q);
    for (int w = 0; w < 132; w++) begin
      wait_lvl(dma, 1'b1);
      if (w == 0) begin
        wb(1'b1, card_read_pkg::OFS_ADDR, 32'h00FF_FFFF, q);
        wb(1'b0, card_read_pkg::OFS_STAT, 32'h0, q);
        chk("busy status", dma ? 32'h0000_0100 : 32'h0000_0101, q);
      end
      wb(1'b0, card_read_pkg::OFS_DATA, 32'h0, q);
      for (int k = 0; k < 4; k++) e[8*k +: 8] = 8'(b0 + 4*w + k) ^ page[7:0];
      chk("data word", e, q);
      if (!dma) wb(1'b1, card_read_pkg::OFS_STAT, 32'h0000_0001, q);
      chk("other request", 32'h0, dma ? irq_o : dma_req_o);
      wait_lvl(dma, 1'b0);
    end
    chk("card commands", c0 + 1, cmd_cnt);
    chk("card command", 32'h0, cmd_byte);
    chk("card page", page, page_seen);
    chk("card bytes", b0 + 528, byte_cnt);
    for (int n = 0; n < 20; n++) begin
      wb(1'b0, card_read_pkg::OFS_STAT, 32'h0, q);
      if (q[8] === 1'b0) break;
    end
    chk("done status", 32'h0000_0002, q);
    wb(1'b1, card_read_pkg::OFS_MASK, 32'h0000_0002, q);
    repeat (3) @(posedge clk);
    chk("done irq", 32'h1, irq_o);
    wb(1'b1, card_read_pkg::OFS_STAT, 32'h0000_0002, q);
    repeat (3) @(posedge clk);
    chk("cleared irq", 32'h0, irq_o);
  endtask : run_page
  task automatic bad_cmds();
    logic [31:0] q;
    logic [7:0] codes [2] = '{8'h01, 8'h50};
    int c0;
    c0 = cmd_cnt;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, card_read_pkg::OFS_MASK, (i == 0) ? 32'h0000_0004 : 32'h0, q);
      wb(1'b1, card_read_pkg::OFS_CMD, {16'h0, codes[i], 8'h00}, q);
      wb(1'b1, card_read_pkg::OFS_ADDR, 32'h0000_0010, q);
      repeat (3) @(posedge clk);
      wb(1'b0, card_read_pkg::OFS_STAT, 32'h0, q);
      chk("bad status", 32'h0000_0004, q);
      chk("bad irq", (i == 0) ? 32'h1 : 32'h0, irq_o);
      wb(1'b1, card_read_pkg::OFS_STAT, 32'h0000_0004, q);
    end
    chk("no card access", c0, cmd_cnt);
  endtask : bad_cmds
  initial begin
    rst <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 8'h00;
    wdat <= 32'h0;
    busy_len <= 8'h06;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reset_regs();
    run_page(1'b0, 24'h03_0507, 8'h06);
    run_page(1'b1, 24'h1A_2B3C, 8'hC8);
    bad_cmds();
    give_verdict();
  end
endmodule : card_page_read_path_bench
